// >>> rtl/reset_release_sync.v
// two-flop release of the asynchronous reset
module reset_release_sync (
  input  wire clk,       // system clock
  input  wire reset_n,   // raw asynchronous reset
  output wire rst_n_s    // reset with synchronous release
);

  reg stage1_q;
  reg stage2_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= 1'b1;
      stage2_q <= stage1_q;
    end
  end

  assign rst_n_s = stage2_q;

endmodule

// >>> rtl/watchdog_prescaler.v
// prescaler turning watchdog clock edges into counter ticks
module watchdog_prescaler (
  input  wire       clk,       // system clock
  input  wire       rst_n,     // synchronised reset
  input  wire       clear,     // restart the division
  input  wire       edge_in,   // one watchdog clock rising edge
  input  wire [3:0] psel,      // prescale select code
  output reg        tick_q     // one-cycle counter tick
);

  reg [10:0] count_q;

  // last count value for each code, divisor minus one
  function [10:0] div_last;
    input [3:0] code;
    begin
      case (code)
        4'h0: div_last = 11'h000;
        4'h1: div_last = 11'h001;
        4'h2: div_last = 11'h003;
        4'h3: div_last = 11'h007;
        4'h4: div_last = 11'h00F;
        4'h5: div_last = 11'h01F;
        4'h6: div_last = 11'h03F;
        4'h7: div_last = 11'h07F;
        4'h8: div_last = 11'h0BF;
        4'h9: div_last = 11'h0FF;
        4'hA: div_last = 11'h17F;
        4'hB: div_last = 11'h1FF;
        4'hC: div_last = 11'h2FF;
        4'hD: div_last = 11'h3FF;
        4'hE: div_last = 11'h5FF;
        default: div_last = 11'h7FF;
      endcase
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 11'h000;
      tick_q  <= 1'b0;
    end else if (clear) begin
      count_q <= 11'h000;
      tick_q  <= 1'b0;
    end else if (edge_in && count_q >= div_last(psel)) begin
      count_q <= 11'h000;
      tick_q  <= 1'b1;
    end else if (edge_in) begin
      count_q <= count_q + 11'h001;
      tick_q  <= 1'b0;
    end else begin
      tick_q  <= 1'b0;
    end
  end

endmodule

// >>> rtl/window_watchdog_status_counter.v
// window watchdog: control, status, live counter and reset generation
//
// The address-and-strobe port was decided locally.
`include "wwdt_map.vh"

module window_watchdog_status_counter (
  input  wire        clk,             // system clock, 25 MHz
  input  wire        reset_n,         // chip reset, active low
  input  wire [7:0]  addr,            // register byte address
  input  wire [31:0] wr_data,         // register write data
  input  wire        wr_en,           // write strobe
  input  wire        rd_en,           // read strobe
  output reg  [31:0] rd_data_q,       // read data, cycle after strobe
  input  wire        watchdog_clock,  // watchdog clock, sampled
  input  wire        debug_halt,      // cpu held by the debugger
  output reg         irq_q,           // level interrupt
  output reg         sys_reset_q      // watchdog system reset request
);

  localparam [2:0] S_IDLE  = 3'b001;
  localparam [2:0] S_RUN   = 3'b010;
  localparam [2:0] S_PULSE = 3'b100;

  // cut on purpose: the pulse count fits four bits
  localparam integer PULSE_CYC  = `RST_PULSE_CYC - 1;
  localparam [3:0]   PULSE_LAST = PULSE_CYC[3:0];

  wire        rst_n_s;
  wire        tick;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [31:0] ctrl_q;
  reg  [31:0] ctrl_d;
  reg         locked_q;
  reg         locked_d;
  reg  [5:0]  count_q;
  reg  [5:0]  count_d;
  reg  [1:0]  status_q;
  reg  [1:0]  status_d;
  reg  [1:0]  irq_enable_q;
  reg  [3:0]  pulse_q;
  reg  [3:0]  pulse_d;
  reg         early_q;
  reg         early_d;
  reg         wclk_q;

  reg         match_set;
  reg         timeout_set;
  reg         presc_clear;

  wire [5:0]  cmp_val    = ctrl_q[`CMP_MSB:`CMP_LSB];
  wire [3:0]  psel       = ctrl_q[`PSEL_MSB:`PSEL_LSB];
  wire        run_bit    = ctrl_q[`BIT_RUN];
  wire        cmp_irq_en = ctrl_q[`BIT_IRQ_EN];
  wire        dbg_ignore = ctrl_q[`BIT_DBG];

  wire        wclk_edge  = watchdog_clock & ~wclk_q;

  // debugger stalls the count unless told to ignore it
  wire        held       = debug_halt & ~dbg_ignore;

  wire        wr_reload  = wr_en && (addr == `OFS_RELOAD) &&
                           (wr_data == `RELOAD_KEY);
  wire        wr_ctrl    = wr_en && (addr == `OFS_CONTROL);
  wire        wr_status  = wr_en && (addr == `OFS_STATUS);
  wire        wr_clr     = wr_en && (addr == `OFS_IRQ_CLEAR);
  wire        wr_irq_en  = wr_en && (addr == `OFS_IRQ_ENABLE);

  wire        in_window  = (count_q <= cmp_val);

  // writes of one through either register clear the flag
  wire [1:0]  clr_bits   = (wr_status ? wr_data[1:0] : 2'b00) |
                           (wr_clr    ? wr_data[1:0] : 2'b00);

  reset_release_sync u_rst (
    .clk     (clk),
    .reset_n (reset_n),
    .rst_n_s (rst_n_s)
  );

  watchdog_prescaler u_presc (
    .clk     (clk),
    .rst_n   (rst_n_s),
    .clear   (presc_clear),
    .edge_in (wclk_edge),
    .psel    (psel),
    .tick_q  (tick)
  );

  always @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      wclk_q <= 1'b0;
    end else begin
      wclk_q <= watchdog_clock;
    end
  end

  // sequencing of count, reload and reset pulse
  always @* begin
    state_d     = state_q;
    ctrl_d      = ctrl_q;
    locked_d    = locked_q;
    count_d     = count_q;
    pulse_d     = pulse_q;
    early_d     = early_q;
    match_set   = 1'b0;
    timeout_set = 1'b0;
    presc_clear = 1'b0;

    // first write wins, later ones are dropped
    if (wr_ctrl && !locked_q) begin
      ctrl_d   = wr_data & `CTRL_MASK;
      locked_d = 1'b1;
    end

    case (state_q)
      S_IDLE: begin
        presc_clear = 1'b1;
        if (run_bit) begin
          state_d = S_RUN;
        end
        if (wr_reload && in_window) begin
          count_d = `COUNT_START;
        end else if (wr_reload) begin
          timeout_set = 1'b1;
          early_d     = 1'b1;
        end
      end

      S_RUN: begin
        if (!run_bit) begin
          state_d     = S_IDLE;
          presc_clear = 1'b1;
        end else if (wr_reload && in_window) begin
          count_d     = `COUNT_START;
          presc_clear = 1'b1;
        end else if (wr_reload) begin
          timeout_set = 1'b1;
          early_d     = 1'b1;
        end else if (tick && !held && count_q == 6'h00) begin
          // 64 ticks from 63 down through 0 ends the period
          timeout_set = 1'b1;
          early_d     = 1'b0;
        end else if (tick && !held) begin
          count_d = count_q - 6'h01;
          if (count_d == cmp_val) begin
            match_set = 1'b1;
          end
        end
      end

      S_PULSE: begin
        presc_clear = 1'b1;
        if (pulse_q == 4'h0) begin
          state_d = S_IDLE;
        end else begin
          pulse_d = pulse_q - 4'h1;
        end
      end

      default: begin
        state_d     = S_IDLE;
        presc_clear = 1'b1;
      end
    endcase

    // a watchdog reset restores control, lock and counter as the chip reset would, but keeps the interrupt enables
    if (timeout_set) begin
      state_d  = S_PULSE;
      pulse_d  = PULSE_LAST;
      count_d  = `COUNT_START;
      ctrl_d   = `CTRL_RESET;
      locked_d = 1'b0;
    end
  end

  // set wins over a clear in the same cycle
  always @* begin
    status_d = status_q & ~clr_bits;
    if (match_set) begin
      status_d[`ST_MATCH] = 1'b1;
    end
    if (timeout_set) begin
      status_d[`ST_TIMEOUT] = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_q  <= S_IDLE;
      ctrl_q   <= `CTRL_RESET;
      locked_q <= 1'b0;
      count_q  <= `COUNT_START;
      pulse_q  <= 4'h0;
      early_q  <= 1'b0;
      status_q <= 2'b00;
    end else begin
      state_q  <= state_d;
      ctrl_q   <= ctrl_d;
      locked_q <= locked_d;
      count_q  <= count_d;
      pulse_q  <= pulse_d;
      early_q  <= early_d;
      status_q <= status_d;
    end
  end

  // interrupt enable register, not locked like control
  always @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      irq_enable_q <= 2'b00;
    end else if (wr_irq_en) begin
      irq_enable_q <= wr_data[1:0];
    end
  end

  // compare interrupt also needs the control enable bit
  always @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (status_d[`ST_MATCH] & irq_enable_q[`ST_MATCH] &
                cmp_irq_en) |
               (status_d[`ST_TIMEOUT] & irq_enable_q[`ST_TIMEOUT]);
    end
  end

  always @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      sys_reset_q <= 1'b0;
    end else begin
      sys_reset_q <= (state_d == S_PULSE);
    end
  end

  // read port; write-only and unmapped addresses read zero
  always @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rd_data_q <= 32'h00000000;
    end else if (!rd_en) begin
      rd_data_q <= 32'h00000000;
    end else if (addr == `OFS_CONTROL) begin
      rd_data_q <= ctrl_q;
    end else if (addr == `OFS_STATUS) begin
      rd_data_q <= {30'h00000000, status_q};
    end else if (addr == `OFS_COUNTER) begin
      rd_data_q <= {26'h0000000, count_q};
    end else if (addr == `OFS_IRQ_ENABLE) begin
      rd_data_q <= {30'h00000000, irq_enable_q};
    end else if (addr == `OFS_INFO) begin
      rd_data_q <= {28'h0000000, in_window, early_q,
                    state_q == S_RUN, locked_q};
    end else begin
      rd_data_q <= 32'h00000000;
    end
  end

endmodule

// >>> rtl/wwdt_map.vh
// register map, field positions and timing counts of the window watchdog
// What this block does
// - prescale codes 1101, 1110, 1111 select divisors 1024, 1536, 2048.
// - longest time-out is the selected divisor times 64 watchdog clock cycles.
// - compare-match interrupt reaches the cpu only while control bit 1 is set.
// - control bit 0 runs the down counter; cleared, the counter stays stopped.
// - status bit 1 records that a watchdog time-out reset happened.
// - status bit 0 sets when the counter counts down to control bits 21 to 16.
// - status flags clear only by writing one; writing zero leaves them.
// - counter value register bits 5 to 0 track the live down counter.
// - reload accepted only with counter at or below compare; else immediate reset.
// - only the first control write after reset takes effect.
// - control bit 31 clear holds the counter while the cpu is debug halted.
// - prescale code 0000 divides by 1, higher codes by larger divisors.
`ifndef WWDT_MAP_VH
`define WWDT_MAP_VH

`define OFS_RELOAD      8'h00
`define OFS_CONTROL     8'h04
`define OFS_STATUS      8'h08
`define OFS_COUNTER     8'h0C
`define OFS_IRQ_CLEAR   8'h10
`define OFS_IRQ_ENABLE  8'h14
`define OFS_INFO        8'h18

// key value is arbitrary
`define RELOAD_KEY      32'h00005AA5
`define CTRL_RESET      32'h003F0800
`define CTRL_MASK       32'h803F0F03

`define BIT_RUN         0
`define BIT_IRQ_EN      1
`define PSEL_LSB        8
`define PSEL_MSB        11
`define CMP_LSB         16
`define CMP_MSB         21
`define BIT_DBG         31

`define ST_MATCH        0
`define ST_TIMEOUT      1

`define COUNT_START     6'h3F
`define RST_PULSE_NS    160
`define CLK_NS          40
`define RST_PULSE_CYC   ((`RST_PULSE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// >>> tb/window_watchdog_status_counter_sva.sv
// port-level checker for the window watchdog block
`include "wwdt_map.vh"
module wwdt_port_chk (
  input logic        clk,         // system clock
  input logic        reset_n,     // chip reset, active low
  input logic [7:0]  addr,        // register byte address
  input logic [31:0] wr_data,     // write data
  input logic        wr_en,       // write strobe
  input logic        rd_en,       // read strobe
  input logic [31:0] rd_data_q,   // read data
  input logic        irq_q,       // level interrupt
  input logic        sys_reset_q  // watchdog reset request
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] en_q;
  // shadow of the interrupt enable register, seen from the bus only
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) en_q <= 2'h0;
    else if (wr_en && addr == `OFS_IRQ_ENABLE) en_q <= wr_data[1:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_rd_idle;
    rd_data_q != 32'h0 |-> $past(rd_en);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  property p_cnt_rd;
    rd_en && addr == `OFS_COUNTER |=> rd_data_q[31:6] == 26'h0;
  endproperty
  a_cnt_rd: assert property (p_cnt_rd)
    else $error("counter read upper bits set");
  property p_st_rd;
    rd_en && addr == `OFS_STATUS |=> rd_data_q[31:2] == 30'h0;
  endproperty
  a_st_rd: assert property (p_st_rd)
    else $error("status read upper bits set");
  property p_en_rd;
    rd_en && addr == `OFS_IRQ_ENABLE |=> rd_data_q == {30'h0, $past(en_q)};
  endproperty
  a_en_rd: assert property (p_en_rd)
    else $error("enable read differs from writes");
  property p_ctl_rd;
    rd_en && addr == `OFS_CONTROL |=> (rd_data_q & ~`CTRL_MASK) == 32'h0;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd)
    else $error("control read has reserved bits");
  property p_hole_rd;
    rd_en && (addr == `OFS_RELOAD || addr == `OFS_IRQ_CLEAR || addr > `OFS_INFO)
      |=> rd_data_q == 32'h0;
  endproperty
  a_hole_rd: assert property (p_hole_rd)
    else $error("write-only or unmapped read not zero");
  property p_rst_len;
    $rose(sys_reset_q) |-> sys_reset_q [*4] ##1 !sys_reset_q;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset pulse length wrong");
  property p_irq_gate;
    en_q == 2'h0 [*3] |-> !irq_q;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt with sources disabled");
  c_rst: cover property ($rose(sys_reset_q));
  c_irq: cover property ($rose(irq_q));
  c_cnt: cover property (rd_en && addr == `OFS_COUNTER);
endmodule
bind window_watchdog_status_counter wwdt_port_chk wwdt_port_chk_i (.clk(clk),
  .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data_q(rd_data_q), .irq_q(irq_q), .sys_reset_q(sys_reset_q));

// >>> tb/window_watchdog_status_counter_test.sv
// self-checking bench for the window watchdog block
`include "wwdt_map.vh"
module window_watchdog_status_counter_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wr_data = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        watchdog_clock = 1'b0;
  logic        debug_halt = 1'b0;
  logic [31:0] rd_data_q;
  logic        irq_q;
  logic        sys_reset_q;
  int          mismatches = 0;
  int          checked = 0;
  int          rst_cyc = 0;
  int          dv [16] = '{1, 2, 4, 8, 16, 32, 64, 128, 192, 256, 384, 512, 768, 1024,
                           1536, 2048};
  always #20 clk = ~clk;
  // pulse length counted here, the pulse may end before a read could see it
  always @(posedge clk) if (sys_reset_q === 1'b1) rst_cyc <= rst_cyc + 1;
  window_watchdog_status_counter window_watchdog_status_counter_i (.clk(clk),
    .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data_q(rd_data_q), .watchdog_clock(watchdog_clock), .debug_halt(debug_halt),
    .irq_q(irq_q), .sys_reset_q(sys_reset_q));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data_q, exp);
  endtask
  // slow edges so the sampled level is never missed
  task automatic wd(input int n);
    repeat (n) begin
      @(posedge clk) watchdog_clock <= 1'b1;
      repeat (2) @(posedge clk);
      watchdog_clock <= 1'b0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic restart;
    @(posedge clk) reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #2_400_000;
    mismatches++;
    close_out;
  end
  initial begin
    restart;
    rd(`OFS_CONTROL, `CTRL_RESET);
    rd(`OFS_COUNTER, 32'h3F);
    rd(`OFS_STATUS, 32'h0);
    rd(`OFS_IRQ_ENABLE, 32'h0);
    rd(`OFS_RELOAD, 32'h0);
    wd(3);
    rd(`OFS_COUNTER, 32'h3F);
    wr(`OFS_CONTROL, 32'h003D0003);
    wr(`OFS_CONTROL, 32'h803F0F00);
    rd(`OFS_CONTROL, 32'h003D0003);
    wr(`OFS_IRQ_ENABLE, 32'h3);
    wd(2);
    rd(`OFS_COUNTER, 32'h3D);
    rd(`OFS_STATUS, 32'h1);
    chk({31'h0, irq_q}, 32'h1);
    @(posedge clk) debug_halt <= 1'b1;
    wd(3);
    rd(`OFS_COUNTER, 32'h3D);
    @(posedge clk) debug_halt <= 1'b0;
    wr(`OFS_STATUS, 32'h0);
    rd(`OFS_STATUS, 32'h1);
    wr(`OFS_STATUS, 32'h1);
    rd(`OFS_STATUS, 32'h0);
    chk({31'h0, irq_q}, 32'h0);
    wr(`OFS_RELOAD, `RELOAD_KEY);
    wr(`OFS_RELOAD, 32'h0);
    rd(`OFS_COUNTER, 32'h3F);
    chk(rst_cyc, 32'h0);
    wr(`OFS_RELOAD, `RELOAD_KEY);
    repeat (8) @(posedge clk);
    #1;
    chk(rst_cyc, 32'h4);
    rd(`OFS_STATUS, 32'h2);
    chk({31'h0, irq_q}, 32'h1);
    wr(`OFS_IRQ_ENABLE, 32'h0);
    rd(`OFS_IRQ_ENABLE, 32'h0);
    chk({31'h0, irq_q}, 32'h0);
    wr(`OFS_IRQ_ENABLE, 32'h3);
    rd(`OFS_CONTROL, `CTRL_RESET);
    rd(`OFS_INFO, 32'hC);
    wr(`OFS_STATUS, 32'h3);
    rd(`OFS_STATUS, 32'h0);
    rst_cyc = 0;
    wr(`OFS_CONTROL, 32'h00000101);
    wd(127);
    rd(`OFS_COUNTER, 32'h0);
    rd(`OFS_STATUS, 32'h1);
    chk({31'h0, irq_q}, 32'h0);
    chk(rst_cyc, 32'h0);
    wd(1);
    repeat (8) @(posedge clk);
    #1;
    chk(rst_cyc, 32'h4);
    rd(`OFS_STATUS, 32'h3);
    rd(`OFS_COUNTER, 32'h3F);
    wr(`OFS_IRQ_CLEAR, 32'h1);
    rd(`OFS_STATUS, 32'h2);
    wr(`OFS_CONTROL, 32'h80000001);
    @(posedge clk) debug_halt <= 1'b1;
    wd(2);
    rd(`OFS_COUNTER, 32'h3D);
    rd(`OFS_INFO, 32'h3);
    @(posedge clk) debug_halt <= 1'b0;
    for (int c = 0; c < 16; c++) begin
      restart;
      wr(`OFS_CONTROL, (c << 8) | 32'h1);
      wd(dv[c] - 1);
      rd(`OFS_COUNTER, 32'h3F);
      wd(1);
      rd(`OFS_COUNTER, 32'h3E);
    end
    close_out;
  end
endmodule
